// ===== dcc_pkg.sv
/*
  Constants, field layout and types of the DMA channel control block.
  Assumes a 32-bit AXI4-Lite register bus and eight channels.
*/
// Summary of operation
// (RULE_01) Global enable low blocks all transfers and stops any running channel.
// (RULE_02) Global enable high lets each channel run by its own settings.
// (RULE_03) All-stopped flag sets once disabled or paused and no access remains.
// (RULE_04) All-stopped flag clears when global enable is 1 and pause is zero.
// (RULE_05) Software writes to the all-stopped flag are ignored.
// (RULE_06) Rotate bit 0 gives fixed priority, channel 0 highest; 1 rotates.
// (RULE_07) Under rotation the last granted channel drops to lowest priority.
// (RULE_08) Nonzero global pause suspends transfers; zero resumes them.
// (RULE_09) A paused channel ignores any transfer request.
// (RULE_10) Block or burst channels need a fresh request after a pause ends.
// (RULE_11) Channel and global enable set: wait for trigger, then transfer.
// (RULE_12) Completion clears channel enable unless keep-enable-on-done is set.
// (RULE_13) Writing channel enable 0 stops the channel until re-enabled.
// (RULE_14) Channel pause suspends and resumes; completion clears it.
// (RULE_15) With reload on, software writes pause and reload counts in one word.
// (RULE_16) Software trigger 1 starts; cleared at completion; 0 mid-transfer stops.
// (RULE_17) Select 000000 is software; 100000 to 111111 pick request lines 0-31.
// (RULE_18) Software triggering needs select zero; any line serves any channel.
// (RULE_19) Block count is blocks minus one, up to 16; zero in demand mode.
// (RULE_20) Block count is readable and drops by one per successful access.
// (RULE_21) Transfer count is transfers minus one, readable, drops per block.
// (RULE_22) Completion: reload restores counts; else success zeroes, failure keeps. Failure here keeps counts even with reload on.
// (RULE_23) Mode 00 block, 01 burst, 10 demand, 11 reserved.
// (RULE_24) Count reload bit enables restoring starting counts on completion.
// (RULE_25) Keep-enable-on-done holds channel enable so hardware triggers repeat.
package dcc_pkg;
  localparam int NCH = 8;
  localparam int NREQ = 32;
  localparam int BC_W = 4;
  localparam int TC_W = 16;
  localparam int SEL_W = 6;
  localparam logic [11:0] OFS_GLOBAL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CH_BASE = 12'h040;
  localparam int G_EN = 31;
  localparam int G_STOP = 30;
  localparam int G_ROT = 28;
  localparam int G_PAUSE_LSB = 24;
  localparam int A_EN = 31;
  localparam int A_PAUSE = 30;
  localparam int A_ST = 29;
  localparam int A_SEL_LSB = 23;
  localparam int A_BC_LSB = 16;
  localparam int A_TC_LSB = 0;
  localparam int B_MODE_LSB = 28;
  localparam int B_RC = 23;
  localparam int B_EM = 0;
  localparam int S_GO_LSB = 8;
  localparam int S_BUSY = 16;
  localparam int S_CH_LSB = 17;
  localparam logic [5:0] SEL_SW = 6'h00;
  localparam logic [1:0] MODE_BLOCK = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_DEMAND = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic en;
    logic pause;
    logic st;
    logic [SEL_W-1:0] sel;
    logic [BC_W-1:0] bc;
    logic [TC_W-1:0] tc;
    logic [BC_W-1:0] bc_init;
    logic [TC_W-1:0] tc_init;
    logic [1:0] mode;
    logic rc;
    logic em;
    logic active;
    logic go;
  } dcc_chan_t;
  localparam dcc_chan_t CHAN_RST = '0;
endpackage

// ===== dcc_dma_channel_control.sv
/*
  Global control, per-channel control, counters and arbitration of an
  eight-channel DMA controller, with an AXI4-Lite register slave.
  Assumes a data mover on the same clock that takes acc_valid/acc_channel,
  performs one access and pulses acc_done or acc_error once per request.
*/
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dcc_dma_channel_control
  import dcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NREQ-1:0] hw_request_line,
  input wire logic acc_done,
  input wire logic acc_error,
  output logic acc_valid,
  output logic [2:0] acc_channel,
  output logic [NCH-1:0] chan_active
);

  function automatic logic [31:0] byte_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // Returns {found, index}: first requester at or after the start channel
  function automatic logic [3:0] pick(input logic [NCH-1:0] w, input logic [2:0] s);
    logic [3:0] r;
    logic [2:0] idx;
    r = '0;
    for (int k = NCH-1; k >= 0; k--) begin
      idx = s + 3'(k);
      if (w[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] chan_a_word(input dcc_chan_t c);
    logic [31:0] v;
    v = '0;
    v[A_EN] = c.en;
    v[A_PAUSE] = c.pause;
    v[A_ST] = c.st;
    v[A_SEL_LSB +: SEL_W] = c.sel;
    v[A_BC_LSB +: BC_W] = c.bc;
    v[A_TC_LSB +: TC_W] = c.tc;
    return v;
  endfunction

  function automatic logic [31:0] chan_b_word(input dcc_chan_t c);
    logic [31:0] v;
    v = '0;
    v[B_MODE_LSB +: 2] = c.mode;
    v[B_RC] = c.rc;
    v[B_EM] = c.em;
    return v;
  endfunction

  // Request line synchroniser
  logic [NREQ-1:0] req_s1_reg;
  logic [NREQ-1:0] req_s2_reg;

  // Bus slave state
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Global control
  logic g_en_reg;
  logic g_stop_reg, g_stop_next;
  logic g_rot_reg;
  logic [3:0] g_pause_reg;

  // Channels and arbiter
  dcc_chan_t ch_reg [NCH];
  dcc_chan_t ch_next [NCH];
  logic [2:0] rr_ptr_reg, rr_ptr_next;
  logic acc_valid_reg, acc_valid_next;
  logic [2:0] acc_ch_reg, acc_ch_next;

  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire ar_take = s_axi_arvalid & arready_reg;

  wire [31:0] wmask = byte_mask(w_strb_reg);
  wire wr_glob = wr_fire & (aw_addr_reg[11:2] == OFS_GLOBAL[11:2]);
  wire wr_stat = wr_fire & (aw_addr_reg[11:2] == OFS_STATUS[11:2]);
  wire wr_chan = wr_fire & (aw_addr_reg[11:6] == OFS_CH_BASE[11:6]);
  wire [2:0] wr_ch = aw_addr_reg[5:3];
  wire wr_b = aw_addr_reg[2];
  wire wr_ok = wr_glob | wr_stat | wr_chan;

  wire [31:0] glob_word = {g_en_reg, g_stop_reg, 1'b0, g_rot_reg, g_pause_reg, 24'h000000};
  wire [31:0] glob_new = (glob_word & ~wmask) | (w_data_reg & wmask);

  wire rd_glob = s_axi_araddr[11:2] == OFS_GLOBAL[11:2];
  wire rd_stat = s_axi_araddr[11:2] == OFS_STATUS[11:2];
  wire rd_chan = s_axi_araddr[11:6] == OFS_CH_BASE[11:6];
  wire [2:0] rd_ch = s_axi_araddr[5:3];
  wire pause_any = g_pause_reg != 4'h0;

  logic [NCH-1:0] act_vec;
  logic [NCH-1:0] go_vec;
  logic [NCH-1:0] want;
  logic [31:0] stat_word;
  logic [31:0] rd_val;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      act_vec[i] = ch_reg[i].active;
      go_vec[i] = ch_reg[i].go;
    end
    stat_word = '0;
    stat_word[NCH-1:0] = act_vec;
    stat_word[S_GO_LSB +: NCH] = go_vec;
    stat_word[S_BUSY] = acc_valid_reg;
    stat_word[S_CH_LSB +: 3] = acc_ch_reg;
    if (rd_glob) begin
      rd_val = glob_word;
    end else if (rd_stat) begin
      rd_val = stat_word;
    end else if (rd_chan) begin
      rd_val = s_axi_araddr[2] ? chan_b_word(ch_reg[rd_ch]) : chan_a_word(ch_reg[rd_ch]); // RULE_20 RULE_21
    end else begin
      rd_val = '0;
    end
  end

  wire rd_ok = rd_glob | rd_stat | rd_chan;

  // Bus handshakes
  always_comb begin
    aw_held_next = (aw_held_reg | aw_take) & ~wr_fire;
    w_held_next = (w_held_reg | w_take) & ~wr_fire;
    awready_next = ~aw_held_next;
    wready_next = ~w_held_next;
    bvalid_next = wr_fire | (bvalid_reg & ~s_axi_bready);
    rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
    arready_next = ~rvalid_next;
  end

  // Channel behaviour
  logic [3:0] pk;
  logic trig;
  logic sw_pulse;
  logic paused;
  logic run_ok;
  logic mine;
  logic ok_done;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      paused = pause_any | ch_reg[i].pause; // RULE_08 RULE_14
      run_ok = g_en_reg & ch_reg[i].en; // RULE_01 RULE_02 RULE_11
      trig = ch_reg[i].sel[SEL_W-1] & req_s2_reg[ch_reg[i].sel[4:0]]; // RULE_17
      want[i] = ch_reg[i].active & ch_reg[i].go & run_ok & ~paused
        & ((ch_reg[i].mode != MODE_DEMAND) | trig) & ~acc_valid_reg;
    end
    pk = pick(want, g_rot_reg ? rr_ptr_reg : 3'h0); // RULE_06
    acc_valid_next = acc_valid_reg;
    acc_ch_next = acc_ch_reg;
    rr_ptr_next = rr_ptr_reg;
    if (acc_valid_reg & (acc_done | acc_error)) begin
      acc_valid_next = 1'b0;
    end else if (pk[3]) begin
      acc_valid_next = 1'b1;
      acc_ch_next = pk[2:0];
      rr_ptr_next = pk[2:0] + 3'h1; // RULE_07
    end

    for (int i = 0; i < NCH; i++) begin
      ch_next[i] = ch_reg[i];
      sw_pulse = 1'b0;
      if (wr_chan & (wr_ch == 3'(i))) begin
        if (wr_b) begin
          ch_next[i].mode = (w_data_reg[B_MODE_LSB +: 2] & wmask[B_MODE_LSB +: 2])
            | (ch_reg[i].mode & ~wmask[B_MODE_LSB +: 2]); // RULE_23
          ch_next[i].rc = wmask[B_RC] ? w_data_reg[B_RC] : ch_reg[i].rc; // RULE_24
          ch_next[i].em = wmask[B_EM] ? w_data_reg[B_EM] : ch_reg[i].em; // RULE_25
        end else begin
          ch_next[i].en = wmask[A_EN] ? w_data_reg[A_EN] : ch_reg[i].en;
          ch_next[i].pause = wmask[A_PAUSE] ? w_data_reg[A_PAUSE] : ch_reg[i].pause;
          ch_next[i].st = wmask[A_ST] ? w_data_reg[A_ST] : ch_reg[i].st;
          ch_next[i].sel = (w_data_reg[A_SEL_LSB +: SEL_W] & wmask[A_SEL_LSB +: SEL_W])
            | (ch_reg[i].sel & ~wmask[A_SEL_LSB +: SEL_W]);
          ch_next[i].bc = (w_data_reg[A_BC_LSB +: BC_W] & wmask[A_BC_LSB +: BC_W])
            | (ch_reg[i].bc & ~wmask[A_BC_LSB +: BC_W]);
          ch_next[i].tc = (w_data_reg[A_TC_LSB +: TC_W] & wmask[A_TC_LSB +: TC_W])
            | (ch_reg[i].tc & ~wmask[A_TC_LSB +: TC_W]);
          ch_next[i].bc_init = ch_next[i].bc;
          ch_next[i].tc_init = ch_next[i].tc;
          sw_pulse = wmask[A_ST] & w_data_reg[A_ST] & (ch_next[i].sel == SEL_SW); // RULE_16
          if (wmask[A_ST] & ~w_data_reg[A_ST] & ch_reg[i].active) begin
            ch_next[i].active = 1'b0; // RULE_16
            ch_next[i].go = 1'b0;
          end
        end
      end
      paused = pause_any | ch_next[i].pause;
      run_ok = g_en_reg & ch_next[i].en;
      trig = sw_pulse | (ch_next[i].sel[SEL_W-1] & req_s2_reg[ch_next[i].sel[4:0]]); // RULE_17
      mine = acc_valid_reg & (acc_ch_reg == 3'(i)) & ch_reg[i].active;
      ok_done = 1'b0;
      if (ch_next[i].active & ~run_ok) begin
        ch_next[i].active = 1'b0; // RULE_01 RULE_13
        ch_next[i].go = 1'b0;
      end else if (paused) begin
        ch_next[i].go = 1'b0; // RULE_09 RULE_10
      end else if (run_ok & trig) begin
        if (~ch_next[i].active) begin
          ch_next[i].bc_init = ch_next[i].bc; // RULE_11
          ch_next[i].tc_init = ch_next[i].tc;
        end
        ch_next[i].active = 1'b1;
        ch_next[i].go = 1'b1;
      end
      if (mine & acc_error) begin
        ch_next[i].active = 1'b0;
        ch_next[i].go = 1'b0;
        ch_next[i].pause = 1'b0;
        ch_next[i].st = 1'b0;
        ch_next[i].en = ch_reg[i].em & ch_next[i].en; // RULE_12 RULE_22
      end else if (mine & acc_done & ch_next[i].active) begin
        if (ch_reg[i].bc != '0) begin
          ch_next[i].bc = ch_reg[i].bc - BC_W'(1); // RULE_20
        end else if (ch_reg[i].tc != '0) begin
          ch_next[i].tc = ch_reg[i].tc - TC_W'(1); // RULE_21
          ch_next[i].bc = ch_reg[i].bc_init;
          if (ch_reg[i].mode == MODE_BLOCK) begin
            ch_next[i].go = 1'b0;
          end
        end else begin
          ok_done = 1'b1;
        end
      end
      if (ok_done) begin
        ch_next[i].active = 1'b0;
        ch_next[i].go = 1'b0;
        ch_next[i].pause = 1'b0; // RULE_14
        ch_next[i].st = 1'b0; // RULE_16
        ch_next[i].en = ch_reg[i].em & ch_next[i].en; // RULE_12 RULE_25
        ch_next[i].bc = ch_reg[i].rc ? ch_reg[i].bc_init : '0; // RULE_22 RULE_24
        ch_next[i].tc = ch_reg[i].rc ? ch_reg[i].tc_init : '0; // RULE_22
      end
    end

    g_stop_next = g_stop_reg;
    if (g_en_reg & ~pause_any) begin
      g_stop_next = 1'b0; // RULE_04
    end else if (~acc_valid_reg) begin
      g_stop_next = 1'b1; // RULE_03
    end
  end

  always_ff @(posedge aclk) begin
    req_s1_reg <= hw_request_line;
    req_s2_reg <= req_s1_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_reg <= rd_val;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // The stop flag is hardware-owned; a bus write never reaches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g_en_reg <= 1'b0;
      g_rot_reg <= 1'b0;
      g_pause_reg <= 4'h0;
      g_stop_reg <= 1'b0;
    end else begin
      if (wr_glob) begin
        g_en_reg <= glob_new[G_EN];
        g_rot_reg <= glob_new[G_ROT];
        g_pause_reg <= glob_new[G_PAUSE_LSB +: 4];
      end
      g_stop_reg <= g_stop_next; // RULE_05
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rr_ptr_reg <= 3'h0;
      acc_valid_reg <= 1'b0;
      acc_ch_reg <= 3'h0;
      for (int i = 0; i < NCH; i++) begin
        ch_reg[i] <= CHAN_RST;
      end
    end else begin
      rr_ptr_reg <= rr_ptr_next;
      acc_valid_reg <= acc_valid_next;
      acc_ch_reg <= acc_ch_next;
      for (int i = 0; i < NCH; i++) begin
        ch_reg[i] <= ch_next[i];
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign acc_valid = acc_valid_reg;
  assign acc_channel = acc_ch_reg;
  assign chan_active = act_vec;

endmodule // dcc_dma_channel_control

// ===== dcc_monitor.sv
/*
  Port checker of the DMA channel control block: bus and access handshakes.
  Assumes one clock, aclk, with synchronous active-low reset aresetn.
*/
`timescale 1ns/1ps
module dcc_monitor
  import dcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic acc_done,
  input wire logic acc_error,
  input wire logic acc_valid,
  input wire logic [2:0] acc_channel,
  input wire logic [NCH-1:0] chan_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  acc_hold_a: assert property (acc_valid && !acc_done && !acc_error |=> acc_valid && $stable(acc_channel))
    else $error("access request changed before its answer");
  acc_free_a: assert property (acc_valid && (acc_done || acc_error) |=> !acc_valid)
    else $error("access request held after its answer");
  err_end_a: assert property (acc_valid && acc_error |-> ##[1:2] ((chan_active & (8'h01 << acc_channel)) == 8'h00))
    else $error("channel still active after failed access");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
endmodule // dcc_monitor

bind dcc_dma_channel_control dcc_monitor u_dcc_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .acc_done, .acc_error, .acc_valid, .acc_channel, .chan_active);

// ===== dcc_mover.sv
/*
  Data mover model at the far side of the access port.
  Answers each access delay+1 cycles after acc_valid rises, with an error pulse while fail is high.
*/
`timescale 1ns/1ps
module dcc_mover
  import dcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic acc_valid,
  input wire logic [3:0] delay,
  input wire logic fail,
  output logic acc_done,
  output logic acc_error
);
  logic [3:0] wait_reg;
  always_ff @(posedge aclk) begin
    acc_done <= 1'b0;
    acc_error <= 1'b0;
    if (!aresetn) begin
      wait_reg <= 4'h0;
    end else if (acc_valid && !acc_done && !acc_error) begin
      // One answer per access, never while the port is idle
      if (wait_reg == delay) begin
        acc_done <= !fail;
        acc_error <= fail;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // dcc_mover

// ===== test_dma_channel_control.sv
/*
  Self-checking bench of the DMA channel control block with a data mover model.
  Assumes the register map and bus timing of the block's package.
*/
`timescale 1ns/1ps
module test_dma_channel_control
  import dcc_pkg::*;
;
  localparam logic [31:0] EN = 32'h1 << A_EN;
  localparam logic [31:0] STB = 32'h1 << A_ST;
  localparam logic [31:0] STOP = 32'h1 << G_STOP;
  localparam logic [31:0] ROT = 32'h1 << G_ROT;
  localparam logic [31:0] BURST = 32'(MODE_BURST) << B_MODE_LSB;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, fail = 1'b0, prev_v = 1'b0, hung = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] delay = 4'h0;
  logic [NREQ-1:0] hw = '0;
  logic awready, wready, bvalid, arready, rvalid, acc_done, acc_error, acc_valid;
  logic [1:0] bresp, rresp;
  logic [2:0] acc_channel;
  logic [NCH-1:0] chan_active;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [2:0] exp_g[$];
  int errors = 0, n_tests = 0, seed, i, k;

  dcc_dma_channel_control u_dcc_dma_channel_control (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hw_request_line(hw), .acc_done(acc_done), .acc_error(acc_error), .acc_valid(acc_valid),
    .acc_channel(acc_channel), .chan_active(chan_active));
  dcc_mover u_dcc_mover (.aclk(aclk), .aresetn(aresetn), .acc_valid(acc_valid), .delay(delay), .fail(fail),
    .acc_done(acc_done), .acc_error(acc_error));

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic miss(input string m);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic stall();
    miss("wait timed out");
    hung = 1'b1;
  endtask

  function automatic logic [11:0] ca(input int n);
    return OFS_CH_BASE + 12'(8 * n);
  endfunction

  function automatic logic [11:0] cb(input int n);
    return OFS_CH_BASE + 12'(8 * n + 4);
  endfunction

  function automatic logic [31:0] bc(input int n);
    return 32'(n) << A_BC_LSB;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic b;
    b = 1'b0;
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge aclk);
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
      b = (bvalid === 1'b1);
      bready <= !b;
    end
    if (!b) stall();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic v;
    v = 1'b0;
    exp_r.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !v; n++) begin
      @(posedge aclk);
      arvalid <= arvalid && !arready;
      v = (rvalid === 1'b1);
      rready <= !v;
    end
    if (!v) stall();
  endtask

  task automatic g(input logic [2:0] c, input int n);
    repeat (n) exp_g.push_back(c);
  endtask

  // Waits out the expected grants, then a quiet window in which any grant is a fault
  task automatic settle(input string s);
    int n;
    for (n = 0; n < 3000 && (exp_g.size() > 0 || acc_valid !== 1'b0); n++) @(posedge aclk);
    if (n == 3000) stall();
    repeat (20) @(posedge aclk);
    $display("test %s done", s);
  endtask

  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) begin
      n_tests++;
      if (bresp !== exp_b.pop_front()) miss("write response");
    end
    if (rvalid === 1'b1 && rready) begin
      n_tests++;
      if ({rresp, rdata} !== exp_r.pop_front()) miss("read data");
    end
    if (acc_valid === 1'b1 && !prev_v) begin
      n_tests++;
      if (exp_g.size() == 0) miss("unexpected grant");
      else if (acc_channel !== exp_g.pop_front()) miss("grant to wrong channel");
    end
    prev_v <= acc_valid;
  end

  initial begin
    wait (hung);
    summarize();
  end

  initial begin
    seed = 32'he5debcea;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_GLOBAL, STOP);
    rd(ca(0), 32'h0);
    rd(cb(0), 32'h0);
    rd(12'h800, 32'h0, RESP_SLVERR);
    wr(12'h800, 32'hffffffff, RESP_SLVERR);
    wr(OFS_STATUS, 32'hffffffff);
    rd(OFS_STATUS, 32'h0);
    wr(ca(0), EN | STB);
    settle("disabled");
    wr(ca(0), 32'h0);
    wr(OFS_GLOBAL, EN | STOP);
    rd(OFS_GLOBAL, EN);
    wr(cb(0), BURST);
    g(0, 4);
    wr(ca(0), EN | STB | bc(1) | 32'h1);
    settle("burst");
    rd(ca(0), 32'h0);
    for (i = 0; i < 4; i++) begin
      k = $unsigned($random(seed)) % NREQ;
      hw <= ~(32'h1 << k);
      wr(cb(2), 32'(i) << B_MODE_LSB);
      wr(ca(2), EN | (32'(6'h20 + k) << A_SEL_LSB) | 32'h1);
      settle("other lines");
      g(2, 2);
      hw <= '1;
      settle("request line");
      hw <= '0;
      rd(ca(2), 32'(6'h20 + k) << A_SEL_LSB);
    end
    wr(cb(1), BURST | (32'h1 << B_RC) | (32'h1 << B_EM));
    g(1, 3);
    wr(ca(1), EN | STB | bc(2));
    settle("reload");
    rd(ca(1), EN | bc(2));
    wr(ca(1), 32'h0);
    fail <= 1'b1;
    wr(cb(5), BURST);
    g(5, 1);
    wr(ca(5), EN | STB | bc(2));
    settle("failed access");
    fail <= 1'b0;
    rd(ca(5), bc(2));
    k = 1 + $unsigned($random(seed)) % 15;
    wr(OFS_GLOBAL, EN | (32'(k) << G_PAUSE_LSB));
    rd(OFS_GLOBAL, EN | STOP | (32'(k) << G_PAUSE_LSB));
    wr(cb(3), BURST);
    wr(ca(3), EN | STB | bc(1));
    settle("global pause");
    wr(OFS_GLOBAL, EN);
    rd(OFS_GLOBAL, EN);
    wr(ca(3), EN | (32'h1 << A_PAUSE) | STB | bc(1));
    settle("channel pause");
    g(3, 2);
    wr(ca(3), EN | STB | bc(1));
    settle("restart");
    delay <= 4'h8;
    wr(cb(4), BURST);
    for (i = 0; i < 2; i++) begin
      g(4, 2);
      wr(ca(4), EN | STB | bc(3) | 32'h3);
      for (k = 0; k < 500 && exp_g.size() > 0; k++) @(posedge aclk);
      if (k == 500) stall();
      wr(ca(4), i == 0 ? EN | bc(3) | 32'h3 : 32'h0);
      settle("channel off");
      rd(ca(4), i == 0 ? EN | bc(3) | 32'h3 : 32'h0);
    end
    delay <= 4'h0;
    wr(cb(6), BURST);
    wr(cb(7), BURST);
    for (i = 0; i < 2; i++) begin
      wr(OFS_GLOBAL, 32'h0);
      wr(ca(6), EN | (32'h25 << A_SEL_LSB) | bc(1));
      wr(ca(7), EN | (32'h25 << A_SEL_LSB) | bc(1));
      hw <= 32'h20;
      g(6, 1);
      g(6 + i, 1);
      g(7 - i, 1);
      g(7, 1);
      wr(OFS_GLOBAL, EN | (i == 1 ? ROT : 32'h0));
      settle("arbitration");
      hw <= '0;
    end
    summarize();
  end
endmodule // test_dma_channel_control
